// ===== logic/jtp_pkg.sv
// Shared constants for the test access port: instruction codes, word layouts,
// security bit positions and the controller state type.
// Assumes the security word is delivered by the fuse loader on the system clock.
package jtp_pkg;

   localparam int IR_W = 4;
   localparam int DR_W = 32;

   // Instruction codes.
   localparam logic [3:0] INS_EXTEST = 4'h0;
   localparam logic [3:0] INS_SAMPLE = 4'h1;
   localparam logic [3:0] INS_DEVICE_IDENTITY_WORD = 4'h2;
   localparam logic [3:0] INS_USERCODE = 4'h3;
   localparam logic [3:0] INS_CHIP = 4'h4;
   localparam logic [3:0] INS_OTP = 4'h5;
   localparam logic [3:0] INS_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // Identification word field widths, bit 0 is the fixed marker bit.
   localparam int ID_VER_W = 4;
   localparam int ID_PART_W = 16;
   localparam int ID_MFR_W = 11;

   // User code word layout.
   localparam int USER_TAG_LSB = 22;
   localparam int USER_TAG_MSB = 31;
   localparam int USER_UNUSED_W = 6;
   localparam int USER_REV_W = 16;

   // Security word bit positions.
   localparam int SEC_JTAG_OFF = 0;
   localparam int SEC_BOOT_OTP = 5;
   localparam int SEC_OTP_BLOCK = 13;
   localparam logic [31:0] SEC_RESET = 32'h0000_0000;

   // Consecutive high TMS samples that always reach the reset state.
   localparam int TMS_RESET_CNT = 5;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } jtp_state_e;

endpackage

// ===== logic/jtp_bscan_chain.sv
// Boundary scan chain, one cell per I/O pin, clocked by the test clock.
// Assumes the pad ring muxes test_out onto the pins while drive is high.
`timescale 1ns/1ps
module jtp_bscan_chain #(
   parameter int N = 8
) (
   // Test clock and reset.
   input wire logic tck,
   input wire logic rst_n,
   // Pins and chain control.
   input wire logic [N-1:0] pin_in,
   input wire logic cap,
   input wire logic shf,
   input wire logic upd,
   input wire logic extest,
   input wire logic si,
   output logic so,
   // Test drive towards the pads.
   output logic [N-1:0] test_out,
   output logic drive
);
   logic [N-1:0] pin_s1_reg;
   logic [N-1:0] pin_s2_reg;
   logic [N:0] chain;

   if (N < 1)
   begin : g_bad
      $error("jtp_bscan_chain needs at least one cell");
   end

   assign chain[N] = si;
   assign so = chain[0];

   // Pins are asynchronous to the test clock, so they are synchronised first.
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end
      else
      begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   for (genvar i = 0; i < N; i++)
   begin : g_cell
      logic cell_reg;
      logic out_reg;
      assign chain[i] = cell_reg;
      assign test_out[i] = out_reg;
      always_ff @(posedge tck or negedge rst_n)
      begin
         if (!rst_n)
            cell_reg <= 1'b0;
         else if (cap)
            cell_reg <= pin_s2_reg[i];
         else if (shf)
            cell_reg <= chain[i+1];
      end
      always_ff @(negedge tck or negedge rst_n)
      begin
         if (!rst_n)
            out_reg <= 1'b0;
         else if (upd)
            out_reg <= cell_reg;
      end
   end

   always_ff @(negedge tck or negedge rst_n)
   begin
      if (!rst_n)
         drive <= 1'b0;
      else
         drive <= extest;
   end

endmodule

// ===== logic/jtp_tap_port.sv
// Test access port: TAP controller, instruction and data registers, identity
// and user code words, onward chip TAP path and fuse-driven locks.
// Assumes TMS/TDI are launched on falling TCK and the fuse loader strobes
// sec_valid once on ref_clk; chip_tdo comes from logic clocked by TCK.
//
// How it works
// - One standard TAP with a boundary chain over the I/O pins is offered.
// - The instruction path is four bits and the main data path thirty-two bits.
// - Chip and fuse instructions hand TMS and TDI onward to the chip TAP and return its TDO.
// - Five consecutive high TMS samples always bring the controller to its reset state.
// - The identity instruction captures version, part and maker fields from bit 31 down.
// - The user code instruction captures the fuse user tag, an unused field and the revision.
// - An unprogrammed fuse array, or one not yet loaded, yields an all-zero fuse user tag.
// - The active-low reset acts asynchronously and boot waits for the clock generator lock.
// - Security bits 31 to 22 are reported as the user code extension.
// - Security bit 0 shuts the port: no drive on TDO and no onward access.
// - Security bit 13 refuses all fuse array access from the port.
`timescale 1ns/1ps
module jtp_tap_port #(
   parameter int BSR_LEN = 8,
   parameter logic [3:0] ID_VERSION = 4'h0, // Arbitrary value.
   parameter logic [15:0] ID_PART = 16'h0001, // Arbitrary value.
   parameter logic [10:0] ID_MAKER = 11'h001, // Arbitrary value.
   parameter logic [15:0] SILICON_REV = 16'h0001 // Arbitrary value.
) (
   // System clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Fuse loader and boot control.
   input wire logic [31:0] sec_word,
   input wire logic sec_valid,
   input wire logic pll_lock,
   output logic boot_start,
   output logic boot_from_otp,
   // Test port pins.
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Onward chip TAP.
   input wire logic chip_tdo,
   output logic chip_sel,
   output logic chip_tms,
   output logic chip_tdi,
   output logic otp_jtag_en,
   // Boundary chain.
   input wire logic [BSR_LEN-1:0] pin_in,
   output logic [BSR_LEN-1:0] bsr_out,
   output logic bsr_drive
);
   if (BSR_LEN < 1)
   begin : g_bad
      $error("jtp_tap_port needs a boundary chain");
   end

   // System domain.
   logic rst_q1_reg, rst_q2_reg;
   logic lock_s1_reg, lock_s2_reg;
   logic [31:0] sec_hold_reg;
   logic sec_ready_reg;
   logic boot_start_reg, boot_from_otp_reg;
   wire sys_rst_n = rst_q2_reg;

   // Test clock domain.
   logic trst_q1_reg, trst_q2_reg;
   logic rdy_s1_reg, rdy_s2_reg;
   logic sec_taken_reg;
   logic [31:0] sec_tck_reg;
   jtp_pkg::jtp_state_e state_reg, state_next;
   logic [3:0] ir_shift_reg, ir_reg;
   logic [31:0] dr_shift_reg;
   logic bypass_reg;
   logic tdo_reg, tdo_oe_reg;
   logic chip_sel_reg, chip_tms_reg, chip_tdi_reg, otp_en_reg;
   logic bsr_so;
   wire tck_rst_n = trst_q2_reg;

   // The board keeps rst_b low long enough; release is synchronised here.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_q1_reg <= 1'b0;
         rst_q2_reg <= 1'b0;
      end
      else
      begin
         rst_q1_reg <= 1'b1;
         rst_q2_reg <= rst_q1_reg;
      end
   end

   // Reset acts at once; boot is held until lock and the fuse word are in.
   wire boot_go = lock_s2_reg && sec_ready_reg && !boot_start_reg;
   always_ff @(posedge ref_clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         lock_s1_reg <= 1'b0;
         lock_s2_reg <= 1'b0;
         sec_hold_reg <= jtp_pkg::SEC_RESET;
         sec_ready_reg <= 1'b0;
         boot_start_reg <= 1'b0;
         boot_from_otp_reg <= 1'b0;
      end
      else
      begin
         lock_s1_reg <= pll_lock;
         lock_s2_reg <= lock_s1_reg;
         if (sec_valid && !sec_ready_reg)
         begin
            sec_hold_reg <= sec_word;
            sec_ready_reg <= 1'b1;
         end
         if (boot_go)
         begin
            boot_start_reg <= 1'b1;
            boot_from_otp_reg <= sec_hold_reg[jtp_pkg::SEC_BOOT_OTP];
         end
      end
   end
   assign boot_start = boot_start_reg;
   assign boot_from_otp = boot_from_otp_reg;

   // Test logic reset follows rst_b at once and releases on TCK.
   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trst_q1_reg <= 1'b0;
         trst_q2_reg <= 1'b0;
      end
      else
      begin
         trst_q1_reg <= 1'b1;
         trst_q2_reg <= trst_q1_reg;
      end
   end

   // The fuse word is frozen on the same edge that sec_ready rises, so only the flag crosses.
   // Until it has crossed the port stays locked, which errs on the safe side.
   always_ff @(posedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
      begin
         rdy_s1_reg <= 1'b0;
         rdy_s2_reg <= 1'b0;
         sec_taken_reg <= 1'b0;
         sec_tck_reg <= jtp_pkg::SEC_RESET;
      end
      else
      begin
         rdy_s1_reg <= sec_ready_reg;
         rdy_s2_reg <= rdy_s1_reg;
         if (rdy_s2_reg && !sec_taken_reg)
         begin
            sec_taken_reg <= 1'b1;
            sec_tck_reg <= sec_hold_reg;
         end
      end
   end

   wire jtag_off = !sec_taken_reg || sec_tck_reg[jtp_pkg::SEC_JTAG_OFF];
   wire otp_block = sec_tck_reg[jtp_pkg::SEC_OTP_BLOCK];

   // Controller next state; all-high TMS walks to reset in at most five steps.
   always_comb
   begin
      case (state_reg)
         jtp_pkg::ST_TLR: state_next = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_RTI;
         jtp_pkg::ST_RTI: state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
         jtp_pkg::ST_SEL_DR: state_next = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
         jtp_pkg::ST_CAP_DR: state_next = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
         jtp_pkg::ST_SH_DR: state_next = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
         jtp_pkg::ST_EX1_DR: state_next = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PA_DR;
         jtp_pkg::ST_PA_DR: state_next = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
         jtp_pkg::ST_EX2_DR: state_next = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
         jtp_pkg::ST_UPD_DR: state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
         jtp_pkg::ST_SEL_IR: state_next = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_CAP_IR;
         jtp_pkg::ST_CAP_IR: state_next = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
         jtp_pkg::ST_SH_IR: state_next = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
         jtp_pkg::ST_EX1_IR: state_next = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PA_IR;
         jtp_pkg::ST_PA_IR: state_next = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
         jtp_pkg::ST_EX2_IR: state_next = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
         jtp_pkg::ST_UPD_IR: state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
         default: state_next = jtp_pkg::ST_TLR;
      endcase
   end

   wire st_tlr = state_reg == jtp_pkg::ST_TLR;
   wire st_cap_ir = state_reg == jtp_pkg::ST_CAP_IR;
   wire st_sh_ir = state_reg == jtp_pkg::ST_SH_IR;
   wire st_upd_ir = state_reg == jtp_pkg::ST_UPD_IR;
   wire st_cap_dr = state_reg == jtp_pkg::ST_CAP_DR;
   wire st_sh_dr = state_reg == jtp_pkg::ST_SH_DR;
   wire st_upd_dr = state_reg == jtp_pkg::ST_UPD_DR;

   // Instruction decode; a locked port loads only bypass on update, but reset and Test-Logic-Reset still select the identity word.
   wire sel_id = ir_reg == jtp_pkg::INS_DEVICE_IDENTITY_WORD;
   wire sel_user = ir_reg == jtp_pkg::INS_USERCODE;
   wire sel_bsr = (ir_reg == jtp_pkg::INS_EXTEST) || (ir_reg == jtp_pkg::INS_SAMPLE);
   wire sel_otp = (ir_reg == jtp_pkg::INS_OTP) && !otp_block && !jtag_off;
   wire sel_chip = ((ir_reg == jtp_pkg::INS_CHIP) && !jtag_off) || sel_otp;
   wire sel_word = sel_id || sel_user;
   wire [3:0] ir_load = jtag_off ? jtp_pkg::INS_BYPASS : ir_shift_reg;

   wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   // The tag stays zero until fuses are in and is zero on a blank array.
   wire [31:0] user_word = {sec_tck_reg[jtp_pkg::USER_TAG_MSB:jtp_pkg::USER_TAG_LSB],
                            {jtp_pkg::USER_UNUSED_W{1'b0}}, SILICON_REV};

   wire dr_out = sel_word ? dr_shift_reg[0] : sel_bsr ? bsr_so : sel_chip ? chip_tdo : bypass_reg;
   wire tdo_next = st_sh_ir ? ir_shift_reg[0] : dr_out;

   always_ff @(posedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
         state_reg <= jtp_pkg::ST_TLR;
      else
         state_reg <= state_next;
   end

   // Instruction path, four bits, defaulting to the identity word.
   always_ff @(posedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
      begin
         ir_shift_reg <= jtp_pkg::IR_CAPTURE;
         ir_reg <= jtp_pkg::INS_DEVICE_IDENTITY_WORD;
      end
      else
      begin
         if (st_cap_ir)
            ir_shift_reg <= jtp_pkg::IR_CAPTURE;
         else if (st_sh_ir)
            ir_shift_reg <= {tdi, ir_shift_reg[3:1]};
         if (st_tlr)
            ir_reg <= jtp_pkg::INS_DEVICE_IDENTITY_WORD;
         else if (st_upd_ir)
            ir_reg <= ir_load;
      end
   end

   // Data path: 32-bit word register or single bypass stage.
   always_ff @(posedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
      begin
         dr_shift_reg <= '0;
         bypass_reg <= 1'b0;
      end
      else if (st_cap_dr)
      begin
         dr_shift_reg <= sel_user ? user_word : id_word;
         bypass_reg <= 1'b0;
      end
      else if (st_sh_dr)
      begin
         dr_shift_reg <= {tdi, dr_shift_reg[31:1]};
         bypass_reg <= tdi;
      end
   end

   // TDO changes only on falling TCK and floats outside shift states.
   always_ff @(negedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
      begin
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end
      else
      begin
         tdo_reg <= tdo_next;
         tdo_oe_reg <= (st_sh_ir || st_sh_dr) && !jtag_off;
      end
   end
   assign tdo = tdo_reg;
   assign tdo_oe = tdo_oe_reg;

   // Onward path: the chip TAP sees TMS and TDI one TCK later.
   always_ff @(posedge tck or negedge tck_rst_n)
   begin
      if (!tck_rst_n)
      begin
         chip_sel_reg <= 1'b0;
         chip_tms_reg <= 1'b1;
         chip_tdi_reg <= 1'b0;
         otp_en_reg <= 1'b0;
      end
      else
      begin
         chip_sel_reg <= sel_chip;
         chip_tms_reg <= sel_chip ? tms : 1'b1;
         chip_tdi_reg <= sel_chip ? tdi : 1'b0;
         otp_en_reg <= sel_otp;
      end
   end
   assign chip_sel = chip_sel_reg;
   assign chip_tms = chip_tms_reg;
   assign chip_tdi = chip_tdi_reg;
   assign otp_jtag_en = otp_en_reg;

   jtp_bscan_chain #(
      .N(BSR_LEN)
   ) u_bscan (
      .tck(tck),
      .rst_n(tck_rst_n),
      .pin_in(pin_in),
      .cap(st_cap_dr && sel_bsr),
      .shf(st_sh_dr && sel_bsr),
      .upd(st_upd_dr && sel_bsr),
      .extest((ir_reg == jtp_pkg::INS_EXTEST) && !jtag_off),
      .si(tdi),
      .so(bsr_so),
      .test_out(bsr_out),
      .drive(bsr_drive)
   );

   a_tms_reset_five: assert property (@(posedge tck) disable iff (!tck_rst_n)
      tms [*5] |=> state_reg == jtp_pkg::ST_TLR)
      else $error("five high TMS samples did not reach reset");

   a_ir_update_load: assert property (@(posedge tck) disable iff (!tck_rst_n)
      st_upd_ir && !jtag_off |=> ir_reg == $past(ir_shift_reg))
      else $error("instruction not loaded from shift stage");

   a_id_capture_word: assert property (@(posedge tck) disable iff (!tck_rst_n)
      st_cap_dr && sel_id |=> dr_shift_reg == {ID_VERSION, ID_PART, ID_MAKER, 1'b1})
      else $error("identity word not captured");

   a_user_tag_field: assert property (@(posedge tck) disable iff (!tck_rst_n)
      st_cap_dr && sel_user |=> dr_shift_reg[31:22] == sec_tck_reg[31:22] && dr_shift_reg[15:0] == SILICON_REV)
      else $error("user code word fields wrong");

   a_blank_tag_zero: assert property (@(posedge tck) disable iff (!tck_rst_n)
      st_cap_dr && sel_user && (!sec_taken_reg || sec_tck_reg[31:22] == 10'h000) |=> dr_shift_reg[31:22] == 10'h000)
      else $error("fuse user tag not zero on a blank or unloaded array");

   a_shift_msb_in: assert property (@(posedge tck) disable iff (!tck_rst_n)
      st_sh_dr ##1 st_sh_dr |-> dr_shift_reg[31] == $past(tdi) && dr_shift_reg[30:0] == $past(dr_shift_reg[31:1]))
      else $error("data path does not shift 32 bits");

   a_port_locked_quiet: assert property (@(posedge tck) disable iff (!tck_rst_n)
      jtag_off && $past(jtag_off) |-> !tdo_oe_reg && !chip_sel_reg)
      else $error("locked port still reachable");

   a_otp_block_en: assert property (@(posedge tck) disable iff (!tck_rst_n)
      $past(otp_block) |-> !otp_en_reg)
      else $error("fuse access open while blocked");

   a_chip_tdi_pass: assert property (@(posedge tck) disable iff (!tck_rst_n)
      sel_chip |=> chip_sel_reg && chip_tdi_reg == $past(tdi) && chip_tms_reg == $past(tms))
      else $error("chip TAP path not passing TMS and TDI");

   a_tdo_idle_float: assert property (@(posedge tck) disable iff (!tck_rst_n)
      !st_sh_ir && !st_sh_dr && !$past(st_sh_ir) && !$past(st_sh_dr) |-> !tdo_oe_reg)
      else $error("TDO driven outside shift states");

   a_extest_drives: assert property (@(posedge tck) disable iff (!tck_rst_n)
      ir_reg == jtp_pkg::INS_EXTEST && !jtag_off ##1 ir_reg == jtp_pkg::INS_EXTEST && !jtag_off |-> bsr_drive)
      else $error("boundary drive missing in extest");

   a_boot_after_lock: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
      $rose(boot_start_reg) |-> $past(lock_s2_reg) && $past(sec_ready_reg))
      else $error("boot started without lock");

endmodule

// ===== tb/jtp_dbg_model.sv
// Behavioural boundary-scan controller that drives the test pins of the port.
// Assumes the port samples on rising tck and updates tdo on falling tck.
`timescale 1ns/1ps
module jtp_dbg_model (
   // Test pins.
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // The board pulls tdo up, so a released line reads as one.
   wire logic tdo_line = tdo_oe ? tdo : 1'b1;
   logic s;

   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One cycle of a frame; tck stands still low between frames.
   // Outside a shift tdi is toggled so no stale level can pass for data.
   task automatic clk(input logic t, input logic d, input logic sh, output logic q);
      tms = t;
      tdi = sh ? d : ~tdi;
      #16;
      q = tdo_line;
      tck = 1'b1;
      #16;
      tck = 1'b0;
   endtask

   task automatic path(input logic [4:0] t, input int k);
      for (int i = 0; i < k; i++)
         clk(t[i], 1'b0, 1'b0, s);
   endtask

   task automatic tlr();
      path(5'h1F, 5);
   endtask

   // Shifts n bits least significant first, then goes through Update to Run-Test/Idle.
   task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      for (int i = 0; i < n; i++)
      begin
         clk(i == n - 1, din[i], 1'b1, q);
         dout = {q, dout[31:1]};
      end
      dout = dout >> (32 - n);
      path(5'h01, 2);
   endtask

   task automatic ir(input logic [3:0] code, output logic [3:0] cap);
      logic [31:0] w;
      path(5'h06, 5);
      scan(4, {28'h0, code}, w);
      cap = w[3:0];
   endtask

   task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
      path(5'h02, 4);
      scan(n, din, dout);
   endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the test access port, with a controller model on the pins.
// Assumes the fuse loader and board signals are driven on ref_clk.
`timescale 1ns/1ps
module tb_top;
   // Identity values are arbitrary.
   localparam logic [3:0] ID_V = 4'h3;
   localparam logic [15:0] ID_P = 16'hA5C3;
   localparam logic [10:0] ID_M = 11'h2B1;
   localparam logic [15:0] REV = 16'h0102;
   localparam logic [31:0] ID_EXP = {ID_V, ID_P, ID_M, 1'b1};

   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] sec_word = 32'h0;
   logic sec_valid = 1'b0;
   logic pll_lock = 1'b0;
   logic chip_tdo = 1'b0;
   logic [7:0] pin_in = 8'h00;
   wire logic tck, tms, tdi, tdo, tdo_oe, boot_start, boot_from_otp;
   wire logic chip_sel, chip_tms, chip_tdi, otp_jtag_en, bsr_drive;
   wire logic [7:0] bsr_out;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] w;
   logic [31:0] sec;
   logic [3:0] c;
   logic [3:0] codes [3] = '{jtp_pkg::INS_OTP, jtp_pkg::INS_BYPASS, 4'h9};

   always #20 ref_clk = ~ref_clk;

   jtp_tap_port #(.BSR_LEN(8), .ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M), .SILICON_REV(REV)) uut (
      .ref_clk(ref_clk), .rst_b(rst_b), .sec_word(sec_word), .sec_valid(sec_valid), .pll_lock(pll_lock),
      .boot_start(boot_start), .boot_from_otp(boot_from_otp), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .chip_tdo(chip_tdo), .chip_sel(chip_sel), .chip_tms(chip_tms), .chip_tdi(chip_tdi),
      .otp_jtag_en(otp_jtag_en), .pin_in(pin_in), .bsr_out(bsr_out), .bsr_drive(bsr_drive));

   jtp_dbg_model dbg (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("FAIL %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("FAIL %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // Holds reset with tck running, releases it, then delivers one fuse word.
   task automatic power_up(input logic [31:0] s, input logic lock);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      pll_lock <= lock;
      sec_word <= s;
      dbg.tlr();
      @(negedge ref_clk);
      chk1("boot_start", 1'b0, boot_start);
      chk1("tdo_oe", 1'b0, tdo_oe);
      chk1("chip_tms", 1'b1, chip_tms);
      chk1("bsr_drive", 1'b0, bsr_drive);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sec_valid <= 1'b1;
      @(posedge ref_clk);
      sec_valid <= 1'b0;
      dbg.tlr();
   endtask

   task automatic boot_wait(input logic otp);
      int n;
      n = 0;
      while (boot_start !== 1'b1 && n < 8)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk1("boot_start", 1'b1, boot_start);
      chk1("boot_from_otp", otp, boot_from_otp);
   endtask

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   initial
   begin
      power_up(32'h0000_0021, 1'b1);
      boot_wait(1'b1);
      dbg.ir(jtp_pkg::INS_CHIP, c);
      chk32("locked_ir", 32'hF, {28'h0, c});
      chk1("chip_sel", 1'b0, chip_sel);
      dbg.dr(32, 32'h0, w);
      chk32("locked_dr", 32'hFFFF_FFFF, w);
      $display("test locked done");

      sec = 32'hB540_2000;
      power_up(sec, 1'b0);
      repeat (8) @(negedge ref_clk);
      chk1("boot_start", 1'b0, boot_start);
      @(posedge ref_clk);
      pll_lock <= 1'b1;
      boot_wait(1'b0);
      dbg.dr(32, 32'h0, w);
      chk32("device_identity_word", ID_EXP, w);
      dbg.ir(jtp_pkg::INS_USERCODE, c);
      chk32("ir_capture", {28'h0, jtp_pkg::IR_CAPTURE}, {28'h0, c});
      dbg.dr(32, 32'h0, w);
      chk32("usercode", {sec[31:22], 6'h00, REV}, w);
      dbg.tlr();
      dbg.dr(32, 32'h0, w);
      chk32("device_identity_word", ID_EXP, w);
      foreach (codes[i])
      begin
         dbg.ir(codes[i], c);
         chk1("otp_jtag_en", 1'b0, otp_jtag_en);
         dbg.dr(32, 32'h9C3A_5E71, w);
         chk32("bypass", 32'h3874_BCE2, w);
      end
      $display("test fuse done");

      power_up(32'h0, 1'b1);
      boot_wait(1'b0);
      dbg.ir(jtp_pkg::INS_USERCODE, c);
      dbg.dr(32, 32'h0, w);
      chk32("usercode", {16'h0000, REV}, w);
      dbg.ir(jtp_pkg::INS_OTP, c);
      // The fuse enable is registered from the loaded instruction, so it needs one more clock in idle.
      dbg.path(5'h00, 1);
      chk1("otp_jtag_en", 1'b1, otp_jtag_en);
      dbg.ir(jtp_pkg::INS_CHIP, c);
      chk1("chip_sel", 1'b1, chip_sel);
      chk1("chip_tdi", tdi, chip_tdi);
      chk1("chip_tms", 1'b0, chip_tms);
      dbg.dr(32, 32'hFFFF_FFFF, w);
      chk32("chip_dr", 32'h0, w);
      dbg.tlr();
      chk1("chip_tms", 1'b1, chip_tms);
      @(posedge ref_clk);
      pin_in <= 8'hC5;
      dbg.ir(jtp_pkg::INS_SAMPLE, c);
      dbg.dr(8, 32'h0, w);
      chk32("sample", 32'hC5, w);
      dbg.ir(jtp_pkg::INS_EXTEST, c);
      dbg.dr(8, 32'h5A, w);
      chk32("bsr_out", 32'h5A, {24'h0, bsr_out});
      chk1("bsr_drive", 1'b1, bsr_drive);
      $display("test open port done");
      summarize();
   end
endmodule
